/* tsq_cfg.svh */
// Offsets, field positions, reset values and codes of the trigger sequencer registers
`ifndef TSQ_CFG_SVH
`define TSQ_CFG_SVH

`define TSQ_ADDR_W          8
`define TSQ_DATA_W          32
`define TSQ_REG_W           16
`define TSQ_LIM_N           5
`define TSQ_LIM_IDX_W       3
`define TSQ_INT_W           3

`define TSQ_OFF_CST         8'h00
`define TSQ_OFF_LIM_FIRST   8'h04
`define TSQ_OFF_LIM_LAST    8'h14
`define TSQ_OFF_INT_STAT    8'h18
`define TSQ_OFF_INT_MASK    8'h1c

`define TSQ_BIT_MODULE_ON   15
`define TSQ_BIT_HALT_IDLE   13
`define TSQ_BIT_TOGGLE      12
`define TSQ_BIT_SOFT_TRIG   10
`define TSQ_BIT_SINGLE_STEP 9
`define TSQ_BIT_VISIBILITY  8
`define TSQ_BIT_RUN         7
`define TSQ_BIT_WDT_FLAG    6
`define TSQ_BIT_ITM_HI      1
`define TSQ_BIT_ITM_LO      0

`define TSQ_CST_IMPL_MASK   16'hb7c3
`define TSQ_CST_PLAIN_MASK  16'hb383
`define TSQ_CST_RESET       16'h0000
`define TSQ_LIM_RESET       16'h0000

`define TSQ_INT_WDT         0
`define TSQ_INT_TRIG        1
`define TSQ_INT_SOFT        2

`define TSQ_RESP_OKAY       2'h0
`define TSQ_RESP_SLVERR     2'h2

`endif

/* tsq_pkg.sv */
// Types and shared helpers of the trigger sequencer control block
`include "tsq_cfg.svh"
package tsq_pkg;

  typedef enum logic [1:0] {TSQ_RD_IDLE, TSQ_RD_FETCH, TSQ_RD_RESP} tsq_rd_stage_t;

  typedef logic [`TSQ_REG_W-1:0]     tsq_word_t;
  typedef logic [`TSQ_ADDR_W-1:0]    tsq_addr_t;
  typedef logic [`TSQ_LIM_IDX_W-1:0] tsq_lim_idx_t;

  // Byte-lane merge of a 16-bit register
  function automatic tsq_word_t tsq_merge(input tsq_word_t old_v, input tsq_word_t new_v, input logic [1:0] strb);
    tsq_word_t res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      res[15:8] = new_v[15:8];
    end
    return res;
  endfunction : tsq_merge

  // Word index of a limit register
  function automatic tsq_lim_idx_t tsq_lim_index(input tsq_addr_t addr);
    tsq_addr_t rel;
    rel = addr - `TSQ_OFF_LIM_FIRST;
    return rel[`TSQ_LIM_IDX_W+1:2];
  endfunction : tsq_lim_index

  function automatic logic tsq_is_lim(input tsq_addr_t addr);
    return (addr >= `TSQ_OFF_LIM_FIRST) && (addr <= `TSQ_OFF_LIM_LAST) && (addr[1:0] == 2'h0);
  endfunction : tsq_is_lim

endpackage : tsq_pkg

/* tsq_lim_mem.sv */
// Limit register store with byte-lane writes and two registered read ports
`timescale 1ns/1ps
`include "tsq_cfg.svh"
module tsq_lim_mem #(
  parameter int DEPTH = `TSQ_LIM_N
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Write port
  input  wire logic                  wr_en,
  input  wire tsq_pkg::tsq_lim_idx_t wr_idx,
  input  wire tsq_pkg::tsq_word_t    wr_data,
  input  wire logic [1:0]            wr_strb,
  // Bus read port
  input  wire tsq_pkg::tsq_lim_idx_t rd_a_idx,
  output tsq_pkg::tsq_word_t         rd_a_data,
  // Sequencer read port
  input  wire tsq_pkg::tsq_lim_idx_t rd_b_idx,
  output tsq_pkg::tsq_word_t         rd_b_data
);
  import tsq_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][`TSQ_REG_W-1:0] mem;
    tsq_word_t                        rd_a;
    tsq_word_t                        rd_b;
  } tsq_mem_st_t;

  tsq_mem_st_t st;
  tsq_mem_st_t next_st;

  always_comb begin
    next_st = st;
    if (wr_en && (int'(wr_idx) < DEPTH)) begin
      next_st.mem[wr_idx] = tsq_merge(st.mem[wr_idx], wr_data, wr_strb);
    end
    next_st.rd_a = (int'(rd_a_idx) < DEPTH) ? st.mem[rd_a_idx] : `TSQ_LIM_RESET;
    next_st.rd_b = (int'(rd_b_idx) < DEPTH) ? st.mem[rd_b_idx] : `TSQ_LIM_RESET;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_a_data = st.rd_a;
  assign rd_b_data = st.rd_b;

endmodule : tsq_lim_mem

/* tsq_ctrl.sv */
// Trigger sequencer control/status register bank with AXI4-Lite slave
`timescale 1ns/1ps
`include "tsq_cfg.svh"

module tsq_ctrl #(
  parameter int N_TRIG = 4,
  parameter int PW_W   = 4
) (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // AXI4-Lite write address and data
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire tsq_pkg::tsq_addr_t        s_axi_awaddr,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [`TSQ_DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  // AXI4-Lite write response
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic [1:0]                     s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire tsq_pkg::tsq_addr_t        s_axi_araddr,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [`TSQ_DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  // Device and step command decoder events
  input  wire logic                      idle_mode,
  input  wire logic                      watchdog_timeout,
  input  wire logic                      emit_trigger_cmd,
  input  wire logic [$clog2(N_TRIG)-1:0] trigger_select,
  input  wire logic [PW_W-1:0]           pulse_width_field,
  input  wire logic                      soft_trigger_take,
  // Live counter and timer values, limit register order
  input  wire tsq_pkg::tsq_word_t        live_count [`TSQ_LIM_N],
  // Limit lookup for the decoder
  input  wire tsq_pkg::tsq_lim_idx_t     limit_select,
  output tsq_pkg::tsq_word_t             limit_value,
  // Control outputs
  output logic                           module_on,
  output logic                           module_active,
  output logic                           output_toggle_mode,
  output logic                           soft_trigger,
  output logic                           single_step_on,
  output logic                           sequencer_run,
  output logic [1:0]                     input_trigger_mode,
  output logic [N_TRIG-1:0]              trigger_output_n,
  output logic                           irq
);
  import tsq_pkg::*;

  typedef struct packed {
    logic                     awready;
    logic                     wready;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     aw_held;
    tsq_addr_t                awaddr;
    logic                     w_held;
    logic [`TSQ_DATA_W-1:0]   wdata;
    logic [3:0]               wstrb;
    logic                     arready;
    logic                     rvalid;
    logic [`TSQ_DATA_W-1:0]   rdata;
    logic [1:0]               rresp;
    tsq_rd_stage_t            rd_stage;
    tsq_addr_t                raddr;
    tsq_word_t                cst;
    logic [`TSQ_INT_W-1:0]    int_stat;
    logic [`TSQ_INT_W-1:0]    int_mask;
    logic                     irq;
    logic                     active;
    logic [N_TRIG-1:0]        trig_out;
    logic                     pulse_busy;
    logic [PW_W-1:0]          pulse_cnt;
  } tsq_st_t;

  // Bus handshakes open after reset; every control bit is zero
  localparam tsq_st_t ST_RESET = '{
    awready: 1'b1, wready: 1'b1, arready: 1'b1, rd_stage: TSQ_RD_IDLE,
    cst: `TSQ_CST_RESET, default: '0};

  tsq_st_t      st;
  tsq_st_t      next_st;
  logic         lim_wr_en;
  tsq_lim_idx_t rd_a_idx;
  tsq_word_t    rd_a_data;

  tsq_lim_mem #(
    .DEPTH (`TSQ_LIM_N)
  ) u_lim_mem (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .wr_en     (lim_wr_en),
    .wr_idx    (tsq_lim_index(st.awaddr)),
    .wr_data   (st.wdata[`TSQ_REG_W-1:0]),
    .wr_strb   (st.wstrb[1:0]),
    .rd_a_idx  (rd_a_idx),
    .rd_a_data (rd_a_data),
    .rd_b_idx  (limit_select),
    .rd_b_data (limit_value)
  );

  always_comb begin
    tsq_word_t             wr_val;
    tsq_word_t             rd_val;
    logic                  do_write;
    logic                  read_stat;
    logic [`TSQ_INT_W-1:0] events;
    logic [N_TRIG-1:0]     sel_mask;
    wr_val    = '0;
    rd_val    = '0;
    do_write  = 1'b0;
    read_stat = 1'b0;
    events    = '0;
    sel_mask  = '0;
    lim_wr_en = 1'b0;
    next_st   = st;

    // Write address and data taken in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awready = 1'b0;
      next_st.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wready = 1'b0;
      next_st.wdata  = s_axi_wdata;
      next_st.wstrb  = s_axi_wstrb;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      do_write       = 1'b1;
      next_st.bvalid = 1'b1;
      next_st.bresp  = `TSQ_RESP_OKAY;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid  = 1'b0;
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end

    // Software trigger consumed by the control step command
    // consumed by control step
    if (soft_trigger_take) begin
      next_st.cst[`TSQ_BIT_SOFT_TRIG] = 1'b0;
      events[`TSQ_INT_SOFT]           = st.cst[`TSQ_BIT_SOFT_TRIG];
    end

    if (do_write) begin
      wr_val = tsq_merge(st.cst, st.wdata[`TSQ_REG_W-1:0], st.wstrb[1:0]);
      if (st.awaddr == `TSQ_OFF_CST) begin
        next_st.cst = (wr_val & `TSQ_CST_PLAIN_MASK) | (next_st.cst & ~`TSQ_CST_PLAIN_MASK);
        if (wr_val[`TSQ_BIT_SOFT_TRIG]) begin
          next_st.cst[`TSQ_BIT_SOFT_TRIG] = 1'b1;
        end
        if (st.wstrb[0] && !wr_val[`TSQ_BIT_WDT_FLAG]) begin
          next_st.cst[`TSQ_BIT_WDT_FLAG] = 1'b0;
        end
      end else if (tsq_is_lim(st.awaddr)) begin
        lim_wr_en = !(st.cst[`TSQ_BIT_MODULE_ON] && st.cst[`TSQ_BIT_RUN]);
      end else if (st.awaddr == `TSQ_OFF_INT_MASK) begin
        next_st.int_mask = st.wdata[`TSQ_INT_W-1:0];
      end else if (st.awaddr != `TSQ_OFF_INT_STAT) begin
        next_st.bresp = `TSQ_RESP_SLVERR;
      end
    end

    if (watchdog_timeout) begin
      next_st.cst[`TSQ_BIT_WDT_FLAG] = 1'b1;
      events[`TSQ_INT_WDT]           = 1'b1;
    end

    // Read path: address taken, memory fetch, answer
    rd_a_idx = tsq_lim_index(st.raddr);
    unique case (st.rd_stage)
      TSQ_RD_IDLE: begin
        if (s_axi_arvalid) begin
          next_st.arready  = 1'b0;
          next_st.raddr    = s_axi_araddr;
          next_st.rd_stage = TSQ_RD_FETCH;
          rd_a_idx         = tsq_lim_index(s_axi_araddr);
        end
      end
      TSQ_RD_FETCH: begin
        next_st.rresp = `TSQ_RESP_OKAY;
        if (st.raddr == `TSQ_OFF_CST) begin
          rd_val = st.cst & `TSQ_CST_IMPL_MASK;
        end else if (tsq_is_lim(st.raddr)) begin
          rd_val = st.cst[`TSQ_BIT_VISIBILITY] ? live_count[tsq_lim_index(st.raddr)] : rd_a_data;
        end else if (st.raddr == `TSQ_OFF_INT_STAT) begin
          rd_val    = tsq_word_t'(st.int_stat);
          read_stat = 1'b1;
        end else if (st.raddr == `TSQ_OFF_INT_MASK) begin
          rd_val = tsq_word_t'(st.int_mask);
        end else begin
          next_st.rresp = `TSQ_RESP_SLVERR;
        end
        next_st.rdata    = {{(`TSQ_DATA_W-`TSQ_REG_W){1'b0}}, rd_val};
        next_st.rvalid   = 1'b1;
        next_st.rd_stage = TSQ_RD_RESP;
      end
      TSQ_RD_RESP: begin
        if (s_axi_rready) begin
          next_st.rvalid   = 1'b0;
          next_st.arready  = 1'b1;
          next_st.rd_stage = TSQ_RD_IDLE;
        end
      end
    endcase

    next_st.active = st.cst[`TSQ_BIT_MODULE_ON] && !(st.cst[`TSQ_BIT_HALT_IDLE] && idle_mode);

    // Trigger outputs
    sel_mask = N_TRIG'(1) << trigger_select;
    if (st.pulse_busy) begin
      if (st.pulse_cnt == '0) begin
        next_st.pulse_busy = 1'b0;
        next_st.trig_out   = '0;
      end else begin
        next_st.pulse_cnt = st.pulse_cnt - PW_W'(1);
      end
    end
    if (emit_trigger_cmd && st.active) begin
      events[`TSQ_INT_TRIG] = 1'b1;
      if (st.cst[`TSQ_BIT_TOGGLE]) begin
        next_st.trig_out   = st.trig_out ^ sel_mask;
        next_st.pulse_busy = 1'b0;
      end else begin
        next_st.trig_out   = sel_mask;
        next_st.pulse_busy = 1'b1;
        next_st.pulse_cnt  = pulse_width_field;
      end
    end
    if (!st.cst[`TSQ_BIT_MODULE_ON]) begin
      next_st.trig_out   = '0;
      next_st.pulse_busy = 1'b0;
    end

    // Sticky status: read clears, new event wins
    if (read_stat) begin
      next_st.int_stat = '0;
    end
    next_st.int_stat = next_st.int_stat | events;
    next_st.irq      = |(st.int_stat & st.int_mask);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready      = st.awready;
  assign s_axi_wready       = st.wready;
  assign s_axi_bvalid       = st.bvalid;
  assign s_axi_bresp        = st.bresp;
  assign s_axi_arready      = st.arready;
  assign s_axi_rvalid       = st.rvalid;
  assign s_axi_rdata        = st.rdata;
  assign s_axi_rresp        = st.rresp;
  assign module_on          = st.cst[`TSQ_BIT_MODULE_ON];
  assign module_active      = st.active;
  assign output_toggle_mode = st.cst[`TSQ_BIT_TOGGLE];
  assign soft_trigger       = st.cst[`TSQ_BIT_SOFT_TRIG];
  assign single_step_on     = st.cst[`TSQ_BIT_SINGLE_STEP];
  assign sequencer_run      = st.cst[`TSQ_BIT_RUN];
  assign input_trigger_mode = st.cst[`TSQ_BIT_ITM_HI:`TSQ_BIT_ITM_LO];
  assign trigger_output_n   = st.trig_out;
  assign irq                = st.irq;

endmodule : tsq_ctrl

/* tsq_ctrl_props.sv */
// Assertion checker for the trigger sequencer control bank
`timescale 1ns/1ps
module tsq_ctrl_props #(
  parameter int N_TRIG = 4,
  parameter int PW_W   = 4
) (
  // Clock and reset
  input wire logic                      ref_clk,
  input wire logic                      rst,
  // Register bus handshakes
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic [1:0]                s_axi_bresp,
  // Events
  input wire logic                      idle_mode,
  input wire logic                      emit_trigger_cmd,
  input wire logic [$clog2(N_TRIG)-1:0] trigger_select,
  input wire logic                      soft_trigger_take,
  // Control outputs
  input wire logic                      module_on,
  input wire logic                      module_active,
  input wire logic                      output_toggle_mode,
  input wire logic                      soft_trigger,
  input wire logic [N_TRIG-1:0]         trigger_output_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  a_wr_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_active_off: assert property (!$past(module_on) |-> !module_active)
    else $error("active while off");
  a_active_run: assert property ($past(module_on && !idle_mode) |-> module_active)
    else $error("inactive while on");
  a_off_clears: assert property (!module_on && !module_active |=> trigger_output_n == '0)
    else $error("outputs not cleared");
  a_toggle_flip: assert property (emit_trigger_cmd && module_active && module_on && output_toggle_mode
    |=> trigger_output_n[$past(trigger_select)] != $past(trigger_output_n[trigger_select]))
    else $error("toggle did not flip");
  a_pulse_rise: assert property (emit_trigger_cmd && module_active && module_on && !output_toggle_mode
    |=> trigger_output_n[$past(trigger_select)])
    else $error("pulse missing");
  a_soft_hold: assert property (soft_trigger && !soft_trigger_take |=> soft_trigger)
    else $error("soft trigger lost");
  a_soft_take: assert property (soft_trigger_take |=> !soft_trigger || s_axi_bvalid)
    else $error("soft trigger not consumed");
endmodule : tsq_ctrl_props

bind tsq_ctrl tsq_ctrl_props #(.N_TRIG(N_TRIG), .PW_W(PW_W)) u_props (.ref_clk, .rst, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .idle_mode, .emit_trigger_cmd,
  .trigger_select, .soft_trigger_take, .module_on, .module_active, .output_toggle_mode, .soft_trigger,
  .trigger_output_n);

/* test_tsq_ctrl.sv */
// Self-checking bench of the trigger sequencer control bank
`timescale 1ns/1ps
`include "tsq_cfg.svh"
module test_tsq_ctrl;
  import tsq_pkg::*;
  logic         ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, idle_mode;
  logic         watchdog_timeout, emit_trigger_cmd, soft_trigger_take, module_on, module_active;
  logic         output_toggle_mode, soft_trigger, single_step_on, sequencer_run, irq;
  tsq_addr_t    s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, seed, rd;
  logic [3:0]   s_axi_wstrb, trigger_output_n, pulse_width_field;
  logic [1:0]   s_axi_bresp, s_axi_rresp, trigger_select, input_trigger_mode, rs;
  tsq_word_t    live_count [`TSQ_LIM_N];
  tsq_word_t    lim [`TSQ_LIM_N];
  tsq_word_t    limit_value, cst, w;
  tsq_lim_idx_t limit_select;
  int           err_total, n_tests, cyc;

  tsq_ctrl #(.N_TRIG(4), .PW_W(4)) i_dut (.ref_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .idle_mode, .watchdog_timeout, .emit_trigger_cmd, .trigger_select, .pulse_width_field, .soft_trigger_take,
    .live_count, .limit_select, .limit_value, .module_on, .module_active, .output_toggle_mode, .soft_trigger,
    .single_step_on, .sequencer_run, .input_trigger_mode, .trigger_output_n, .irq);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Soft trigger sets only, watchdog flag clears only
  function automatic tsq_word_t ecst(input tsq_word_t o, input tsq_word_t v);
    return (v & `TSQ_CST_PLAIN_MASK) | ((o | v) & 16'h0400) | (o & v & 16'h0040);
  endfunction : ecst

  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input tsq_addr_t a, input tsq_word_t d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wstrb   <= 4'hf;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      s_axi_awvalid <= pa;
      s_axi_wvalid  <= pw;
    end while (pa || pw);
    do @(posedge ref_clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input tsq_addr_t a);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr

  task automatic rchk(input tsq_addr_t a, input tsq_word_t e);
    rdr(a);
    chk("rdata", {16'h0000, e}, rd);
    chk("rresp", `TSQ_RESP_OKAY, rs);
  endtask : rchk

  task automatic wrc(input tsq_word_t v);
    wr(`TSQ_OFF_CST, v);
    cst = ecst(cst, v);
  endtask : wrc

  task automatic pulse_in(input int k);
    @(posedge ref_clk);
    if (k == 0) watchdog_timeout <= 1'b1;
    else soft_trigger_take <= 1'b1;
    @(posedge ref_clk);
    watchdog_timeout  <= 1'b0;
    soft_trigger_take <= 1'b0;
  endtask : pulse_in

  task automatic emit(input logic [1:0] s, input logic [3:0] pw);
    @(posedge ref_clk);
    emit_trigger_cmd  <= 1'b1;
    trigger_select    <= s;
    pulse_width_field <= pw;
    @(posedge ref_clk);
    emit_trigger_cmd <= 1'b0;
  endtask : emit

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    seed = 32'hec26_3f80;
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'b10_0000;
    {idle_mode, watchdog_timeout, emit_trigger_cmd, soft_trigger_take} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {trigger_select, pulse_width_field, limit_select, cst, err_total, n_tests, cyc} = '0;
    foreach (live_count[i]) live_count[i] = tsq_word_t'(xs());
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a < 32; a += 4) rchk(tsq_addr_t'(a), 16'h0000);
    chk("outs", 0, {module_on, module_active, soft_trigger, sequencer_run, trigger_output_n, irq});
    wr(8'h20, 16'hffff);
    chk("bresp", `TSQ_RESP_SLVERR, rs);
    rdr(8'h20);
    chk("unmapped rresp", `TSQ_RESP_SLVERR, rs);
    chk("unmapped", 32'h0000_0000, rd);
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : tsq_word_t'(xs());
      wrc(w);
      rchk(`TSQ_OFF_CST, cst);
      chk("ctl", {cst[15], cst[12], cst[10:9], cst[7], cst[1:0]}, {module_on, output_toggle_mode,
        soft_trigger, single_step_on, sequencer_run, input_trigger_mode});
    end
    wrc(16'h0400);
    wrc(16'h0000);
    rchk(`TSQ_OFF_CST, cst);
    pulse_in(1);
    cst = cst & ~16'h0400;
    @(negedge ref_clk);
    chk("soft", 0, soft_trigger);
    rchk(`TSQ_OFF_INT_STAT, 16'h0004);
    pulse_in(0);
    cst = cst | 16'h0040;
    rchk(`TSQ_OFF_CST, cst);
    wr(`TSQ_OFF_INT_MASK, 16'h0007);
    repeat (2) @(posedge ref_clk);
    chk("irq", 1, irq);
    rchk(`TSQ_OFF_INT_STAT, 16'h0001);
    repeat (2) @(posedge ref_clk);
    chk("irq", 0, irq);
    wrc(cst);
    rchk(`TSQ_OFF_CST, cst);
    wrc(cst & ~16'h0040);
    rchk(`TSQ_OFF_CST, cst);
    for (int p = 0; p < 3; p++) begin
      wrc(p == 1 ? 16'h0100 : p == 2 ? 16'h8080 : 16'h0000);
      for (int i = 0; i < 5; i++) begin
        if (p == 0) lim[i] = tsq_word_t'(xs());
        if (p != 1) begin
          wr(tsq_addr_t'(4 + 4 * i), p == 2 ? ~lim[i] : lim[i]);
          chk("lim bresp", `TSQ_RESP_OKAY, rs);
        end
        rchk(tsq_addr_t'(4 + 4 * i), p == 1 ? live_count[i] : lim[i]);
        limit_select <= tsq_lim_idx_t'(i);
        repeat (2) @(posedge ref_clk);
        chk("limit", lim[i], limit_value);
      end
    end
    wrc(16'h9000);
    for (int k = 0; k < 2; k++) begin
      emit(2'd2, 4'h0);
      @(negedge ref_clk);
      chk("toggle", k == 0 ? 4'b0100 : 4'b0000, trigger_output_n);
    end
    wrc(16'h8000);
    for (int k = 0; k < 2; k++) begin
      emit(2'd1, k ? 4'h3 : 4'h0);
      for (int i = 0; i <= 3 * k + 1; i++) begin
        @(negedge ref_clk);
        chk("pulse", i <= 3 * k ? 4'b0010 : 4'b0000, trigger_output_n);
        @(posedge ref_clk);
      end
    end
    for (int k = 0; k < 2; k++) begin
      wrc(k ? 16'h8000 : 16'ha000);
      idle_mode <= 1'b1;
      repeat (3) @(posedge ref_clk);
      emit(2'd3, 4'h0);
      @(negedge ref_clk);
      chk("active", k, module_active);
      chk("idle out", k ? 4'b1000 : 4'b0000, trigger_output_n);
      repeat (2) @(posedge ref_clk);
      idle_mode <= 1'b0;
    end
    test_done();
  end
endmodule : test_tsq_ctrl
